// >>> bench/sfrec_host.sv
// Host controller model driving select, serial clock and lanes.
`timescale 1ns/1ns
`default_nettype none
module sfrec_host (
  // Serial link
  output logic ce_n,
  output logic sck,
  output logic [3:0] sio,
  input wire logic [3:0] lane
);
  initial
  begin
    ce_n = 1'b1;
    sck = 1'b0;
    sio = 4'h0;
  end
  // The clock stands low outside frames; select stays low for the whole command.
  task automatic open_sel();
    ce_n = 1'b0;
    #100;
  endtask : open_sel
  // Released lanes are inverted so a stale value never reads as a match.
  task automatic close_sel();
    #100 ce_n = 1'b1;
    sio = ~sio;
    #200;
  endtask : close_sel
  task automatic shift(input int n, input int w, input logic [63:0] v, output logic [63:0] r);
    logic [63:0] m;
    m = (64'h1 << w) - 64'h1;
    r = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sio = 4'((v >> (i * w)) & m);
      #62 sck = 1'b1;
      r = (r << w) | ((w == 1) ? 64'(lane[1]) : 64'(lane) & m);
      #63 sck = 1'b0;
    end
  endtask : shift
endmodule : sfrec_host
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the serial flash read and erase command block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int ERASE_N = 20;
  logic CORE_CLK, SYS_RST, WRITE_ENABLE, AREA_PROTECTED, CE_N, SCK, BUSY, er_blk;
  logic MEM_RD_REQ, MEM_RD_PARAM, MEM_RD_LOCKED, ERASE_REQ, ERASE_BLOCK, QUAD_CMD_MODE;
  logic [3:0] SIO_OUT, SIO_OE, hs, lane;
  logic [7:0] MEM_RD_DATA;
  logic [23:0] MEM_RD_ADDR, ERASE_ADDR, er_addr;
  logic [63:0] r;
  int failures = 0, checked = 0, n_er = 0, n_busy = 0;
  assign lane = (SIO_OE & SIO_OUT) | (~SIO_OE & hs);
  sfrec_host h (.ce_n(CE_N), .sck(SCK), .sio(hs), .lane(lane));
  sfrec_top #(.ERASE_CYCLES(ERASE_N), .MFR_CODE(8'h11), .DEV_TYPE(8'h22), .DEV_CODE(8'h33)) DUT (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CE_N(CE_N), .SCK(SCK), .SIO_IN(lane),
    .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE), .QUAD_CMD_MODE(QUAD_CMD_MODE),
    .WRITE_ENABLE(WRITE_ENABLE),
    .AREA_PROTECTED(AREA_PROTECTED), .BUSY(BUSY), .MEM_RD_REQ(MEM_RD_REQ),
    .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_PARAM(MEM_RD_PARAM), .MEM_RD_DATA(MEM_RD_DATA),
    .MEM_RD_LOCKED(MEM_RD_LOCKED), .ERASE_REQ(ERASE_REQ), .ERASE_BLOCK(ERASE_BLOCK),
    .ERASE_ADDR(ERASE_ADDR));
  // ************************************************************
  // Array model and erase monitor
  // ************************************************************
  // Parameter table bytes are inverted array bytes; byte 01 of each page is read-locked.
  always @(posedge CORE_CLK)
  begin
    if (MEM_RD_REQ)
    begin
      MEM_RD_DATA <= MEM_RD_ADDR[7:0] ^ 8'h5A ^ {8{MEM_RD_PARAM}};
      MEM_RD_LOCKED <= (MEM_RD_ADDR[7:0] == 8'h01);
    end
    if (ERASE_REQ)
    begin
      n_er <= n_er + 1;
      er_blk <= ERASE_BLOCK;
      er_addr <= ERASE_ADDR;
    end
    if (BUSY)
      n_busy <= n_busy + 1;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int dmy);
    h.shift(8, 1, 64'(op), r);
    h.shift(24, 1, 64'(a), r);
    h.shift(dmy, 1, 64'h0, r);
  endtask : cmd
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dmy, input int n,
                    input int w, input logic [63:0] exp);
    h.open_sel();
    cmd(op, a, dmy);
    h.shift(n, w, 64'h0, r);
    h.close_sel();
    check(r, exp);
  endtask : rd
  task automatic ident();
    h.open_sel();
    h.shift(8, 1, 64'h9F, r);
    h.shift(32, 1, 64'h0, r);
    h.close_sel();
    check(r, 64'h11223311);
  endtask : ident
  task automatic dio(input logic [23:0] a, input logic [7:0] m, input logic [63:0] exp);
    h.shift(16, 2, {32'h0, a, m}, r);
    h.shift(8, 2, 64'h0, r);
    h.close_sel();
    check(r, exp);
  endtask : dio
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic we, input logic pr,
                       input int n, input logic [24:0] exp);
    int e0;
    int b0;
    @(posedge CORE_CLK);
    #1 WRITE_ENABLE = we;
    AREA_PROTECTED = pr;
    e0 = n_er;
    b0 = n_busy;
    h.open_sel();
    cmd(op, a, 0);
    h.close_sel();
    for (int i = 0; i < 200 && BUSY !== 1'b0; i++) @(posedge CORE_CLK);
    check(64'(n_er - e0), 64'(n));
    check(64'(n_busy - b0), 64'(n * ERASE_N));
    if (n > 0)
      check({39'h0, er_blk, er_addr}, {39'h0, exp});
  endtask : erase
  // ************************************************************
  // Clock, watchdog and test sequence
  // ************************************************************
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
  initial
  begin
    SYS_RST = 1'b1;
    WRITE_ENABLE = 1'b0;
    AREA_PROTECTED = 1'b0;
    QUAD_CMD_MODE = 1'b0;
    MEM_RD_DATA = 8'h00;
    MEM_RD_LOCKED = 1'b0;
    repeat (16) @(posedge CORE_CLK);
    #1 SYS_RST = 1'b0;
    #100;
    ident();
    @(posedge CORE_CLK);
    #1 QUAD_CMD_MODE = 1'b1;
    h.open_sel();
    h.shift(2, 4, 64'hAF, r);
    h.shift(8, 4, 64'h0, r);
    h.close_sel();
    check(r, 64'h112233);
    @(posedge CORE_CLK);
    #1 QUAD_CMD_MODE = 1'b0;
    rd(8'hEC, 24'h000006, 24, 32, 1, 64'h5C5D5A00);
    h.open_sel();
    h.shift(16, 1, 64'hC001, r);
    h.close_sel();
    rd(8'hEC, 24'h00001E, 24, 32, 1, 64'h44454A4B);
    rd(8'h3B, 24'h1FFFFE, 8, 16, 2, 64'hA4A55A5B);
    rd(8'h5A, 24'h000010, 8, 16, 1, 64'hB5B4);
    h.open_sel();
    h.shift(8, 1, 64'hBB, r);
    dio(24'h000010, 8'hA5, 64'h4A4B);
    h.open_sel();
    dio(24'h000020, 8'h00, 64'h7A7B);
    ident();
    h.open_sel();
    h.shift(8, 1, 64'hBB, r);
    dio(24'h000010, 8'hA0, 64'h4A4B);
    h.open_sel();
    h.shift(8, 1, 64'hFF, r);
    h.close_sel();
    ident();
    erase(8'hD8, 24'h105678, 1'b1, 1'b0, 1, {1'b1, 24'h100000});
    erase(8'hD8, 24'h00C123, 1'b1, 1'b0, 1, {1'b1, 24'h008000});
    erase(8'h20, 24'h123ABC, 1'b1, 1'b0, 1, {1'b0, 24'h123000});
    erase(8'h20, 24'h123ABC, 1'b0, 1'b0, 0, 25'h0);
    erase(8'hD8, 24'h105678, 1'b1, 1'b1, 0, 25'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// >>> hdl/sfrec_pkg.sv
// Constants and types shared by the serial flash read and erase command block.
package sfrec_pkg;
  // ************************************************************
  // Command opcodes
  // ************************************************************
  localparam logic [7:0] OP_WRAP_READ = 8'hEC;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_IDENT = 8'h9F;
  localparam logic [7:0] OP_QUAD_IDENT = 8'hAF;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_QIO_RESET = 8'hFF;
  localparam logic [7:0] OP_SET_BURST = 8'hC0;
  // ************************************************************
  // Field values, phase lengths and geometry
  // ************************************************************
  localparam logic [3:0] CONT_NIBBLE = 4'hA;
  localparam logic [1:0] BURST_LEN_RESET = 2'h0;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_WRAP_CLKS = 6'h18;
  localparam logic [5:0] DUMMY_BYTE_CLKS = 6'h08;
  localparam logic [5:0] DUMMY_QIDENT_CLKS = 6'h02;
  localparam logic [3:0] QIO_RESET_CLKS = 4'h8;
  localparam logic [23:0] MEM_TOP_ADDR = 24'h1FFFFF;
  localparam int TOP_ADDR_BIT = 20;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int ERASE_TIME_MS = 25;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  // ************************************************************
  // Command phases
  // ************************************************************
  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_BLEN, PH_HOLD
  } sfrec_phase_t;
endpackage : sfrec_pkg

// >>> hdl/sfrec_top.sv
// Serial flash read and erase command handling, with its FIFO and pin synchroniser.
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Read data FIFO
// ************************************************************
module sfrec_fifo #(
  parameter int WIDTH = sfrec_pkg::FIFO_WIDTH,
  parameter int DEPTH = sfrec_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;

  assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_reg != rd_reg;
  assign out_data = mem_reg[rd_reg[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule : sfrec_fifo

// ************************************************************
// Three-stage pin synchroniser with agreement filter
// ************************************************************
module sfrec_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // A bit only moves once the second and third stages agree.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg));
    end
  end
endmodule : sfrec_sync

// Summary of operation
// [R1] Wrap read: opcode, address, three dummy bytes
// [R2] Wrap read streams on falling edges
// [R3] Wrap address loops inside burst window
// [R4] Burst windows aligned to burst length
// [R5] Read-locked bytes return zero during wrap
// [R6] Dual output: serial header, two-lane data
// [R7] Linear reads wrap top to zero
// [R8] Dual I/O: address and mode on two lanes
// [R9] Mode nibble A skips next opcode
// [R10] Other mode nibble expects an opcode
// [R11] Quad I/O reset leaves continuation mode
// [R12] Serial ident streams three bytes repeatedly
// [R13] Four-lane ident: nibble opcode, one dummy
// [R14] Parameter read: opcode, address, dummy byte
// [R15] Sector erase sets 4-Kbyte sector ones
// [R16] Sector chosen from address bit 12 up
// [R17] Host sets write enable before erase
// [R18] Block erase sets selected block ones
// [R19] Protected block erase is ignored
// [R20] Block address from bit 13, size-masked
// [R21] Host polls busy or waits erase time
// [R22] Host holds select low whole command
// [R23] Burst length resets to eight bytes
// [R24] Set-burst byte selects 8 to 64
// [R25] Busy from launch until erase ends
// [R26] Erase ignored without write enable
module sfrec_top #(
  parameter int ERASE_CYCLES = sfrec_pkg::ERASE_CYCLES,
  parameter logic [7:0] MFR_CODE = 8'h11, // Arbitrary value.
  parameter logic [7:0] DEV_TYPE = 8'h22, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'h33  // Arbitrary value.
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Serial link pins
  input wire logic CE_N,
  input wire logic SCK,
  input wire logic [3:0] SIO_IN,
  output logic [3:0] SIO_OUT,
  output logic [3:0] SIO_OE,
  // Mode and status
  input wire logic QUAD_CMD_MODE,
  input wire logic WRITE_ENABLE,
  input wire logic AREA_PROTECTED,
  output logic BUSY,
  // Array read port
  output logic MEM_RD_REQ,
  output logic [23:0] MEM_RD_ADDR,
  output logic MEM_RD_PARAM,
  input wire logic [7:0] MEM_RD_DATA,
  input wire logic MEM_RD_LOCKED,
  // Array erase port
  output logic ERASE_REQ,
  output logic ERASE_BLOCK,
  output logic [23:0] ERASE_ADDR
);
  // ************************************************************
  // Pin sampling and edges
  // ************************************************************
  logic [5:0] pins;
  logic ce_n_lvl;
  logic sck_lvl;
  logic [3:0] sio_lvl;
  logic sck_d_reg;
  logic ce_d_reg;
  logic sck_rise;
  logic sck_fall;
  logic ce_fall;
  logic ce_rise;

  sfrec_sync #(.W(6), .INIT(6'h20)) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d({CE_N, SCK, SIO_IN}),
    .q(pins)
  );
  assign ce_n_lvl = pins[5];
  assign sck_lvl = pins[4];
  assign sio_lvl = pins[3:0];

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      sck_d_reg <= 1'b0;
      ce_d_reg <= 1'b1;
    end
    else
    begin
      sck_d_reg <= sck_lvl;
      ce_d_reg <= ce_n_lvl;
    end
  end
  assign sck_rise = sck_lvl && !sck_d_reg && !ce_n_lvl;
  assign sck_fall = !sck_lvl && sck_d_reg && !ce_n_lvl;
  assign ce_fall = !ce_n_lvl && ce_d_reg;
  assign ce_rise = ce_n_lvl && !ce_d_reg;

  // ************************************************************
  // Input shifting and phase strobes
  // ************************************************************
  sfrec_pkg::sfrec_phase_t phase_reg;
  logic [7:0] op_reg;
  logic [5:0] cnt_reg;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic [2:0] in_w;
  logic [5:0] cnt_add;
  logic [5:0] dummy_len;
  logic is_erase;
  logic cmd_done;
  logic addr_done;
  logic mode_done;
  logic dummy_done;
  logic blen_done;

  assign is_erase = op_reg == sfrec_pkg::OP_SECTOR_ERASE || op_reg == sfrec_pkg::OP_BLOCK_ERASE;

  always_comb
  begin
    in_w = 3'd1;
    if (phase_reg == sfrec_pkg::PH_CMD && QUAD_CMD_MODE)
    begin
      in_w = 3'd4; // [R13]
    end
    else if ((phase_reg == sfrec_pkg::PH_ADDR || phase_reg == sfrec_pkg::PH_MODE)
             && op_reg == sfrec_pkg::OP_DUAL_IO)
    begin
      in_w = 3'd2; // [R8]
    end
  end
  assign cnt_add = cnt_reg + 6'(in_w);

  always_comb
  begin
    unique case (in_w)
      3'd2: sh_next = {sh_reg[29:0], sio_lvl[1:0]};
      3'd4: sh_next = {sh_reg[27:0], sio_lvl};
      default: sh_next = {sh_reg[30:0], sio_lvl[0]};
    endcase
  end

  always_comb
  begin
    unique case (op_reg)
      sfrec_pkg::OP_WRAP_READ: dummy_len = sfrec_pkg::DUMMY_WRAP_CLKS; // [R1]
      sfrec_pkg::OP_QUAD_IDENT: dummy_len = sfrec_pkg::DUMMY_QIDENT_CLKS; // [R13]
      default: dummy_len = sfrec_pkg::DUMMY_BYTE_CLKS; // [R6] [R14]
    endcase
  end

  assign cmd_done = sck_rise && phase_reg == sfrec_pkg::PH_CMD
                    && cnt_add == sfrec_pkg::OPCODE_BITS;
  assign addr_done = sck_rise && phase_reg == sfrec_pkg::PH_ADDR
                     && cnt_add == sfrec_pkg::ADDR_BITS;
  assign mode_done = sck_rise && phase_reg == sfrec_pkg::PH_MODE
                     && cnt_add == sfrec_pkg::MODE_BITS;
  assign dummy_done = sck_rise && phase_reg == sfrec_pkg::PH_DUMMY && cnt_add == dummy_len;
  assign blen_done = sck_rise && phase_reg == sfrec_pkg::PH_BLEN
                     && cnt_add == sfrec_pkg::OPCODE_BITS;

  // ************************************************************
  // Command sequencer
  // ************************************************************
  logic cont_reg;
  logic [23:0] addr_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (sck_rise)
    begin
      sh_reg <= sh_next;
    end
  end

  // Rising select always ends the transaction, whatever phase it is in.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || ce_n_lvl)
    begin
      phase_reg <= sfrec_pkg::PH_IDLE; // [R22]
      cnt_reg <= '0;
    end
    else if (ce_fall)
    begin
      phase_reg <= cont_reg ? sfrec_pkg::PH_ADDR : sfrec_pkg::PH_CMD; // [R9] [R10]
      cnt_reg <= '0;
    end
    else if (sck_rise)
    begin
      cnt_reg <= cnt_add;
      if (cmd_done || addr_done || mode_done || dummy_done || blen_done)
      begin
        cnt_reg <= '0;
      end
      if (cmd_done)
      begin
        unique case (sh_next[7:0])
          sfrec_pkg::OP_WRAP_READ, sfrec_pkg::OP_DUAL_OUT, sfrec_pkg::OP_DUAL_IO,
          sfrec_pkg::OP_PARAM_READ, sfrec_pkg::OP_SECTOR_ERASE,
          sfrec_pkg::OP_BLOCK_ERASE: phase_reg <= sfrec_pkg::PH_ADDR; // [R1] [R6] [R14]
          sfrec_pkg::OP_IDENT: phase_reg <= sfrec_pkg::PH_DATA; // [R12]
          sfrec_pkg::OP_QUAD_IDENT: phase_reg <= sfrec_pkg::PH_DUMMY; // [R13]
          sfrec_pkg::OP_SET_BURST: phase_reg <= sfrec_pkg::PH_BLEN; // [R24]
          default: phase_reg <= sfrec_pkg::PH_HOLD;
        endcase
      end
      else if (addr_done)
      begin
        if (op_reg == sfrec_pkg::OP_DUAL_IO)
        begin
          phase_reg <= sfrec_pkg::PH_MODE; // [R8]
        end
        else if (is_erase)
        begin
          phase_reg <= sfrec_pkg::PH_HOLD; // [R15] [R18]
        end
        else
        begin
          phase_reg <= sfrec_pkg::PH_DUMMY;
        end
      end
      else if (mode_done || dummy_done)
      begin
        phase_reg <= sfrec_pkg::PH_DATA;
      end
      else if (blen_done)
      begin
        phase_reg <= sfrec_pkg::PH_HOLD;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      op_reg <= '0;
      addr_reg <= '0;
    end
    else if (ce_fall && cont_reg)
    begin
      op_reg <= sfrec_pkg::OP_DUAL_IO; // [R9]
    end
    else if (cmd_done)
    begin
      op_reg <= sh_next[7:0];
    end
    else if (addr_done)
    begin
      addr_reg <= sh_next[23:0];
    end
  end

  // ************************************************************
  // Continuation mode and burst length
  // ************************************************************
  logic [1:0] blen_reg;
  logic [3:0] clk_cnt_reg;
  logic ones_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || ce_fall)
    begin
      clk_cnt_reg <= '0;
      ones_reg <= 1'b1;
    end
    else if (sck_rise)
    begin
      clk_cnt_reg <= (clk_cnt_reg == 4'hF) ? clk_cnt_reg : clk_cnt_reg + 4'h1;
      ones_reg <= ones_reg && sio_lvl[0];
    end
  end

  // While continuation is armed a reset opcode arrives where the address would.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      cont_reg <= 1'b0;
    end
    else if (mode_done)
    begin
      cont_reg <= sh_next[7:4] == sfrec_pkg::CONT_NIBBLE; // [R9] [R10]
    end
    else if (cmd_done && sh_next[7:0] == sfrec_pkg::OP_QIO_RESET)
    begin
      cont_reg <= 1'b0; // [R11]
    end
    else if (ce_rise && cont_reg && ones_reg && clk_cnt_reg == sfrec_pkg::QIO_RESET_CLKS)
    begin
      cont_reg <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      blen_reg <= sfrec_pkg::BURST_LEN_RESET; // [R23]
    end
    else if (blen_done && sh_next[7:2] == 6'h00)
    begin
      blen_reg <= sh_next[1:0]; // [R24]
    end
  end

  // ************************************************************
  // Byte fetch into the FIFO
  // ************************************************************
  logic fetch_on_reg;
  logic id_src_reg;
  logic wrap_reg;
  logic [23:0] faddr_reg;
  logic [23:0] wbase_reg;
  logic [1:0] id_idx_reg;
  logic rd_pend_reg;
  logic [23:0] wmask;
  logic start_id;
  logic start_mem;
  logic push;
  logic in_ready;
  logic [7:0] push_data;
  logic [7:0] pop_data;
  logic pop_valid;
  logic pop;

  always_comb
  begin
    unique case (blen_reg)
      2'h0: wmask = 24'h000007;
      2'h1: wmask = 24'h00000F;
      2'h2: wmask = 24'h00001F;
      default: wmask = 24'h00003F;
    endcase
  end

  assign start_id = cmd_done && (sh_next[7:0] == sfrec_pkg::OP_IDENT
                    || sh_next[7:0] == sfrec_pkg::OP_QUAD_IDENT);
  assign start_mem = addr_done && !is_erase;
  assign push = fetch_on_reg && (id_src_reg || rd_pend_reg);

  always_comb
  begin
    unique case (id_idx_reg)
      2'h0: push_data = MFR_CODE; // [R12] [R13]
      2'h1: push_data = DEV_TYPE;
      default: push_data = DEV_CODE;
    endcase
    if (!id_src_reg)
    begin
      push_data = (wrap_reg && MEM_RD_LOCKED) ? 8'h00 : MEM_RD_DATA; // [R5]
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || ce_n_lvl)
    begin
      fetch_on_reg <= 1'b0;
      id_src_reg <= 1'b0;
      wrap_reg <= 1'b0;
      faddr_reg <= '0;
      wbase_reg <= '0;
      id_idx_reg <= '0;
    end
    else if (start_id || start_mem)
    begin
      fetch_on_reg <= 1'b1;
      id_src_reg <= start_id;
      wrap_reg <= op_reg == sfrec_pkg::OP_WRAP_READ;
      faddr_reg <= sh_next[23:0] & sfrec_pkg::MEM_TOP_ADDR;
      wbase_reg <= sh_next[23:0] & ~wmask; // [R4]
      id_idx_reg <= '0;
    end
    else
    begin
      if (id_src_reg && push && in_ready)
      begin
        id_idx_reg <= (id_idx_reg == 2'h2) ? 2'h0 : id_idx_reg + 2'h1; // [R12]
      end
      if (MEM_RD_REQ)
      begin
        if (wrap_reg)
        begin
          faddr_reg <= (faddr_reg & ~wmask) | ((faddr_reg + 24'h1) & wmask); // [R3] [R4]
        end
        else
        begin
          faddr_reg <= (faddr_reg + 24'h1) & sfrec_pkg::MEM_TOP_ADDR; // [R7]
        end
      end
    end
  end

  // One read is in flight at a time, so a free slot at request time is kept for it.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      MEM_RD_REQ <= 1'b0;
      MEM_RD_ADDR <= '0;
      MEM_RD_PARAM <= 1'b0;
      rd_pend_reg <= 1'b0;
    end
    else
    begin
      MEM_RD_REQ <= fetch_on_reg && !id_src_reg && in_ready && !MEM_RD_REQ
                    && !rd_pend_reg && !ce_n_lvl;
      rd_pend_reg <= MEM_RD_REQ;
      if (fetch_on_reg && !MEM_RD_REQ)
      begin
        MEM_RD_ADDR <= faddr_reg;
        MEM_RD_PARAM <= op_reg == sfrec_pkg::OP_PARAM_READ; // [R14]
      end
    end
  end

  sfrec_fifo #(.WIDTH(sfrec_pkg::FIFO_WIDTH), .DEPTH(sfrec_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .flush(ce_n_lvl),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop),
    .out_data(pop_data)
  );

  // ************************************************************
  // Output shifter
  // ************************************************************
  logic [7:0] osh_reg;
  logic [3:0] obits_reg;
  logic [7:0] obyte;
  logic [3:0] out_w;

  always_comb
  begin
    unique case (op_reg)
      sfrec_pkg::OP_DUAL_OUT, sfrec_pkg::OP_DUAL_IO: out_w = 4'd2; // [R6] [R8]
      sfrec_pkg::OP_QUAD_IDENT: out_w = 4'd4; // [R13]
      default: out_w = 4'd1;
    endcase
  end
  assign pop = sck_fall && phase_reg == sfrec_pkg::PH_DATA && obits_reg == 4'd0;
  assign obyte = (obits_reg != 4'd0) ? osh_reg : (pop_valid ? pop_data : 8'h00);

  // An empty FIFO at a byte boundary shifts zeros rather than stalling the link.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || ce_n_lvl)
    begin
      SIO_OUT <= '0;
      SIO_OE <= '0;
      osh_reg <= '0;
      obits_reg <= '0;
    end
    else if (sck_fall && phase_reg == sfrec_pkg::PH_DATA)
    begin
      obits_reg <= ((obits_reg == 4'd0) ? 4'd8 : obits_reg) - out_w; // [R2]
      unique case (out_w)
        4'd2:
        begin
          SIO_OUT <= {2'b00, obyte[7:6]};
          SIO_OE <= 4'b0011;
          osh_reg <= {obyte[5:0], 2'b00};
        end
        4'd4:
        begin
          SIO_OUT <= obyte[7:4];
          SIO_OE <= 4'b1111;
          osh_reg <= {obyte[3:0], 4'h0};
        end
        default:
        begin
          SIO_OUT <= {2'b00, obyte[7], 1'b0};
          SIO_OE <= 4'b0010;
          osh_reg <= {obyte[6:0], 1'b0};
        end
      endcase
    end
  end

  // ************************************************************
  // Erase launch and busy timer
  // ************************************************************
  logic [31:0] busy_cnt_reg;
  logic [23:0] blk_base;
  logic erase_ok;
  localparam int TB = sfrec_pkg::TOP_ADDR_BIT;

  always_comb
  begin
    blk_base = {addr_reg[23:16], 16'h0000};
    if (addr_reg[TB:16] == '0 || &addr_reg[TB:16])
    begin
      if (addr_reg[15] == &addr_reg[TB:16])
      begin
        blk_base = {addr_reg[23:13], 13'h0000}; // [R20]
      end
      else
      begin
        blk_base = {addr_reg[23:15], 15'h0000}; // [R20]
      end
    end
  end

  assign erase_ok = ce_rise && phase_reg == sfrec_pkg::PH_HOLD && is_erase
                    && WRITE_ENABLE && !AREA_PROTECTED && !BUSY; // [R17] [R19] [R26]

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      ERASE_REQ <= 1'b0;
      ERASE_BLOCK <= 1'b0;
      ERASE_ADDR <= '0;
      BUSY <= 1'b0;
      busy_cnt_reg <= '0;
    end
    else
    begin
      ERASE_REQ <= erase_ok; // [R15] [R18]
      if (erase_ok)
      begin
        ERASE_BLOCK <= op_reg == sfrec_pkg::OP_BLOCK_ERASE;
        ERASE_ADDR <= (op_reg == sfrec_pkg::OP_BLOCK_ERASE) ? blk_base
                      : {addr_reg[23:12], 12'h000}; // [R16]
        BUSY <= 1'b1; // [R25]
        busy_cnt_reg <= '0;
      end
      else if (BUSY)
      begin
        busy_cnt_reg <= busy_cnt_reg + 32'h1;
        if (busy_cnt_reg == 32'(ERASE_CYCLES - 1))
        begin
          BUSY <= 1'b0; // [R25]
        end
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_erase_end;
    ce_rise && phase_reg == sfrec_pkg::PH_HOLD && is_erase;
  endsequence
  sequence s_erase_go;
    ERASE_REQ && BUSY;
  endsequence

  a_erase_launch: assert property ( // [R15] [R18] [R25]
    s_erase_end ##0 (WRITE_ENABLE && !AREA_PROTECTED && !BUSY) |=> s_erase_go)
    else $error("erase not launched");
  a_erase_guard: assert property ( // [R19] [R26]
    ERASE_REQ |-> $past(WRITE_ENABLE) && !$past(AREA_PROTECTED))
    else $error("erase without enable");
  a_sector_addr: assert property ( // [R16]
    ERASE_REQ && !ERASE_BLOCK |-> ERASE_ADDR[11:0] == 12'h000
    && ERASE_ADDR[23:12] == addr_reg[23:12]) else $error("bad sector");
  a_block_addr: assert property ( // [R20]
    ERASE_REQ && ERASE_BLOCK |-> ERASE_ADDR[12:0] == 13'h0000)
    else $error("bad block base");
  a_busy_hold: assert property ($rose(BUSY) |-> BUSY [*8]) // [R25]
    else $error("busy dropped early");
  a_wrap_window: assert property ( // [R3] [R4]
    MEM_RD_REQ && wrap_reg |-> (MEM_RD_ADDR & ~wmask) == wbase_reg)
    else $error("wrap left window");
  a_lock_zero: assert property ( // [R5]
    push && wrap_reg && !id_src_reg && MEM_RD_LOCKED |-> push_data == 8'h00)
    else $error("locked data leaked");
  a_cont_set: assert property ( // [R9]
    mode_done && sh_next[7:4] == sfrec_pkg::CONT_NIBBLE |=> cont_reg)
    else $error("continuation not armed");
  a_cont_skip: assert property ( // [R9]
    ce_fall && cont_reg |=> phase_reg == sfrec_pkg::PH_ADDR && op_reg == sfrec_pkg::OP_DUAL_IO)
    else $error("no skip");
  a_cont_clear: assert property ( // [R10]
    mode_done && sh_next[7:4] != sfrec_pkg::CONT_NIBBLE |=> !cont_reg)
    else $error("continuation kept");
  a_oe_release: assert property ( // [R2] [R22]
    ce_rise |=> SIO_OE == 4'h0 && phase_reg == sfrec_pkg::PH_IDLE)
    else $error("pins driven after deselect");
endmodule : sfrec_top

`default_nettype wire
